// ---- common/canbt_pkg.sv ----
package canbt_pkg;
    // ==============================================================
    // register map (byte addresses on the AXI4-Lite slave)
    // ==============================================================
    localparam logic [7:0]  CFG_OFFSET    = 8'h00;  // timing configuration
    localparam logic [7:0]  STATUS_OFFSET = 8'h04;  // live timing state
    localparam int          CFG_W         = 19;     // used bits of the config word
    // config reset: prop 2, phase one 3, phase two 2 from its field -> 8 quanta
    localparam logic [31:0] CFG_RESET     = 32'h0001_9100;
    // status field positions
    localparam int          ST_RX_BIT     = 0;      // last received bit
    localparam int          ST_SEG_LSB    = 1;      // segment code, two bits
    localparam int          ST_SYNCED     = 3;      // an edge was used this bit
    localparam int          ST_STARVED    = 4;      // no edge for too many bits
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ==============================================================
    // timing constants, in quanta or bits
    // ==============================================================
    localparam logic [3:0]  IPT_TQ        = 4'h2;   // processing interval
    localparam logic [3:0]  SYNC_TQ       = 4'h1;   // sync segment length
    localparam logic [4:0]  BIT_TQ_MAX    = 5'h19;  // 25 quanta
    localparam logic [2:0]  STUFF_SPAN    = 3'h6;   // bits between edges

    // config word layout, msb first, bit 0 is the prescaler lsb
    typedef struct packed {
        logic [2:0] phase_two_len_field;
        logic       phase_two_source_select;
        logic       triple_sample_select;
        logic [2:0] phase_one_len_field;
        logic [2:0] propagation_len_field;
        logic [1:0] resync_jump_width;
        logic [5:0] quantum_prescale_value;
    } canbt_cfg_t;

    // quantum ticks from the prescaler
    typedef struct packed {
        logic tq_tick;      // end of a quantum
        logic half_tick;    // every half quantum
    } canbt_tick_t;

    typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} canbt_seg_t;
endpackage

// ---- core/canbt_timing.sv ----
`timescale 1ns/100ps
`default_nettype none
module canbt_timing
    import canbt_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // protocol engine side
    input  wire logic        tx_bit,
    input  wire logic        bus_idle,
    output logic             rx_bit,
    output logic             sample_pt,
    output logic             bit_start,
    // bus pins
    input  wire logic        rxd,
    output logic             txd
);
    import canbt_pkg::*;

    // ==============================================================
    // declarations
    // ==============================================================
    canbt_cfg_t  cfg;            // live timing configuration
    logic        cfg_wr;         // pulse after a config write
    logic [31:0] next_cfg_word;  // config merged with byte strobes
    logic        aw_got;         // write address held
    logic        w_got;          // write data held
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    canbt_tick_t tick;           // quantum ticks
    canbt_seg_t  state;          // current segment
    logic [3:0]  seg_q;          // quanta done inside the segment
    logic [4:0]  bit_q;          // quanta done inside the bit
    logic [2:0]  ph1_ext;        // lengthening of phase one
    logic [2:0]  ph2_cut;        // shortening of phase two
    logic        synced;         // an edge was used in this bit
    logic        rxd_q;          // bus level one cycle back
    logic [1:0]  hist;           // half-quantum sample history
    logic [2:0]  quiet_bits;     // bits since the last falling edge
    logic [3:0]  prop_len;
    logic [3:0]  ph1_len;
    logic [3:0]  ph1_end;
    logic [3:0]  ph2_prog;
    logic [3:0]  ph2_base;
    logic [3:0]  ph2_end;
    logic [3:0]  seg_len;
    logic [3:0]  rem_q;          // quanta left in phase two
    logic [2:0]  sjw_len;
    logic [4:0]  bit_len_cfg;    // nominal bit length in quanta
    logic        seg_done;
    logic        fall;
    logic        edge_use;
    logic        hard;
    logic        pos_err;
    logic        neg_err;
    logic        pos_small;
    logic        neg_small;
    logic        sync_now;
    logic        restart;
    logic        launch;
    logic        samp;
    logic        majority;

    // ==============================================================
    // register bus: write channel
    // ==============================================================
    // merge write strobes over the current config; one byte per lane
    always_comb begin
        next_cfg_word = {13'h0000, cfg};
        for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
                next_cfg_word[8*b +: 8] = w_data[8*b +: 8];
            end
        end
    end

    // address and data are taken in either order, then answered together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            cfg           <= canbt_cfg_t'(CFG_RESET[CFG_W-1:0]);
            cfg_wr        <= 1'b0;
        end else begin
            cfg_wr <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                aw_got        <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_got        <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_got && w_got && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr == CFG_OFFSET) begin
                    // a config change restarts the timing chain
                    cfg         <= canbt_cfg_t'(next_cfg_word[CFG_W-1:0]);
                    cfg_wr      <= 1'b1;
                    s_axi_bresp <= RESP_OKAY;
                end else if (aw_addr == STATUS_OFFSET) begin
                    s_axi_bresp <= RESP_OKAY; // read-only, write ignored
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got        <= 1'b0;
                w_got         <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ==============================================================
    // register bus: read channel
    // ==============================================================
    // data is captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            if (s_axi_araddr == CFG_OFFSET) begin
                s_axi_rdata <= {13'h0000, cfg};
            end else if (s_axi_araddr == STATUS_OFFSET) begin
                s_axi_rdata[ST_RX_BIT]            <= rx_bit;
                s_axi_rdata[ST_SEG_LSB +: 2]      <= state;
                s_axi_rdata[ST_SYNCED]            <= synced;
                s_axi_rdata[ST_STARVED]           <= (quiet_bits > STUFF_SPAN);
            end else begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==============================================================
    // quantum prescaler
    // ==============================================================
    canbt_tq_gen u_tq_gen (
        .aclk                   (aclk),
        .aresetn                (aresetn),
        .restart                (restart),
        .quantum_prescale_value (cfg.quantum_prescale_value),
        .tick                   (tick)
    );

    // ==============================================================
    // segment lengths
    // ==============================================================
    always_comb begin
        prop_len = {1'b0, cfg.propagation_len_field} + 4'h1;
        ph1_len  = {1'b0, cfg.phase_one_len_field} + 4'h1;
        ph1_end  = ph1_len + {1'b0, ph1_ext};
        ph2_prog = {1'b0, cfg.phase_two_len_field} + 4'h1;
        // phase two base never shorter than the processing interval; the resync cut can take phase two below it
        if (cfg.phase_two_source_select) begin
            ph2_base = (ph2_prog < IPT_TQ) ? IPT_TQ : ph2_prog;
        end else begin
            ph2_base = (ph1_len < IPT_TQ) ? IPT_TQ : ph1_len;
        end
        ph2_end     = ph2_base - {1'b0, ph2_cut};
        sjw_len     = {1'b0, cfg.resync_jump_width} + 3'h1;
        bit_len_cfg = {1'b0, SYNC_TQ} + {1'b0, prop_len} + {1'b0, ph1_len} + {1'b0, ph2_base};
        unique case (state)
            SEG_SYNC: seg_len = SYNC_TQ;
            SEG_PROP: seg_len = prop_len;
            SEG_PH1:  seg_len = ph1_end;
            SEG_PH2:  seg_len = ph2_end;
        endcase
        rem_q    = ph2_end - seg_q;
        seg_done = tick.tq_tick && ((seg_q + 4'h1) == seg_len);
    end

    // ==============================================================
    // edge handling and synchronization
    // ==============================================================
    // only recessive to dominant edges carry clock information
    always_comb begin
        fall      = rxd_q && !rxd;
        edge_use  = fall && !synced && rx_bit;
        hard      = edge_use && bus_idle;
        // a node sending dominant ignores edges with positive error
        pos_err   = edge_use && !bus_idle && txd &&
                    ((state == SEG_PROP) || (state == SEG_PH1));
        neg_err   = edge_use && !bus_idle && (state == SEG_PH2);
        pos_small = (bit_q <= {2'b00, sjw_len});
        neg_small = (rem_q <= {1'b0, sjw_len});
        sync_now  = hard || (pos_err && pos_small) || (neg_err && neg_small);
        restart   = sync_now || cfg_wr;
        launch    = (seg_done && (state == SEG_PH2) && !restart) ||
                    (neg_err && neg_small);
        samp      = seg_done && (state == SEG_PH1) && !restart;
        majority  = (rxd && hist[0]) || (rxd && hist[1]) || (hist[0] && hist[1]);
    end

    // bus level history for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxd_q <= 1'b1;
        end else begin
            rxd_q <= rxd;
        end
    end

    // ==============================================================
    // segment sequencer
    // ==============================================================
    // a restart places the edge inside a fresh sync segment
    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            state <= SEG_SYNC;
            seg_q <= 4'h0;
            bit_q <= 5'h00;
        end else if (tick.tq_tick) begin
            if (seg_done) begin
                seg_q <= 4'h0;
                unique case (state)
                    SEG_SYNC: state <= SEG_PROP;
                    SEG_PROP: state <= SEG_PH1;
                    SEG_PH1:  state <= SEG_PH2;
                    SEG_PH2:  state <= SEG_SYNC;
                endcase
                bit_q <= (state == SEG_PH2) ? 5'h00 : bit_q + 5'h01;
            end else begin
                seg_q <= seg_q + 4'h1;
                bit_q <= bit_q + 5'h01;
            end
        end
    end

    // phase adjustments last one bit; a bigger error gets only one jump width
    always_ff @(posedge aclk) begin
        if (!aresetn || restart || launch) begin
            ph1_ext <= 3'h0;
            ph2_cut <= 3'h0;
        end else if (pos_err && !pos_small) begin
            ph1_ext <= sjw_len;
        end else if (neg_err && !neg_small) begin
            ph2_cut <= sjw_len;
        end
    end

    // one synchronization per bit; a sync restart also counts as the bit's one, a config write clears it
    always_ff @(posedge aclk) begin
        if (!aresetn || cfg_wr) begin
            synced <= 1'b0;
        end else if (hard || pos_err || neg_err || (edge_use && state == SEG_SYNC)) begin
            synced <= 1'b1;
        end else if (launch) begin
            synced <= 1'b0;
        end
    end

    // ==============================================================
    // sampling
    // ==============================================================
    // history shifts every half quantum, so it holds the two earlier samples
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hist <= 2'h3;
        end else if (tick.half_tick) begin
            hist <= {hist[0], rxd};
        end
    end

    // received value; triple mode only helps when quanta are long
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_bit    <= 1'b1;
            sample_pt <= 1'b0;
        end else begin
            sample_pt <= samp;
            if (samp) begin
                rx_bit <= cfg.triple_sample_select ? majority : rxd;
            end
        end
    end

    // ==============================================================
    // transmit launch and edge watchdog
    // ==============================================================
    // the level is held from sync to the next sync, recessive after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txd       <= 1'b1;
            bit_start <= 1'b0;
        end else begin
            bit_start <= launch;
            if (launch) begin
                txd <= tx_bit;
            end
        end
    end

    // bits without an edge; saturates, flags a stuffing breach by the far end
    always_ff @(posedge aclk) begin
        if (!aresetn || fall) begin
            quiet_bits <= 3'h0;
        end else if (launch && (quiet_bits != 3'h7)) begin
            quiet_bits <= quiet_bits + 3'h1;
        end
    end

    // ==============================================================
    // checks
    // ==============================================================
    a_sync_one_tq: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == SEG_SYNC && tick.tq_tick && !restart) |=> (state == SEG_PROP))
        else $error("sync segment not one quantum");
    a_prop_len_end: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == SEG_PROP && tick.tq_tick && !restart &&
         seg_q == {1'b0, cfg.propagation_len_field}) |=> (state == SEG_PH1))
        else $error("propagation segment length wrong");
    a_ph1_sample: assert property (@(posedge aclk) disable iff (!aresetn)
        samp |=> (state == SEG_PH2) && sample_pt)
        else $error("sample point not at phase one end");
    a_ph2_floor: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == SEG_PH2) |-> (ph2_base >= IPT_TQ))
        else $error("phase two below processing interval");
    a_bit_len_max: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_len_cfg <= BIT_TQ_MAX)
        else $error("bit length above maximum");
    a_single_sample: assert property (@(posedge aclk) disable iff (!aresetn)
        (samp && !cfg.triple_sample_select) |=> (rx_bit == $past(rxd)))
        else $error("single sample value wrong");
    a_majority_vote: assert property (@(posedge aclk) disable iff (!aresetn)
        (samp && cfg.triple_sample_select && rxd && hist[1]) |=> rx_bit)
        else $error("majority vote wrong");
    a_tx_held: assert property (@(posedge aclk) disable iff (!aresetn)
        !launch |=> $stable(txd))
        else $error("transmit level changed inside bit");
    a_hard_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        hard |=> (state == SEG_SYNC) && (bit_q == 5'h00) && synced)
        else $error("hard sync did not restart bit");
    a_jump_lengthen: assert property (@(posedge aclk) disable iff (!aresetn)
        (pos_err && !pos_small && !cfg_wr) |=> (ph1_ext == $past(sjw_len)))
        else $error("phase one not lengthened by jump width");
    a_cfg_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_wr |=> (state == SEG_SYNC) && (seg_q == 4'h0))
        else $error("config write did not restart timing");
endmodule
`default_nettype wire

// ---- core/canbt_tq_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
module canbt_tq_gen
    import canbt_pkg::*;
(
    input  wire logic           aclk,
    input  wire logic           aresetn,
    input  wire logic           restart,
    input  wire logic [5:0]     quantum_prescale_value,
    output canbt_pkg::canbt_tick_t tick
);
    // ==============================================================
    // quantum prescaler
    // ==============================================================
    logic [6:0] cnt;        // oscillator cycles inside the quantum
    logic [6:0] last;       // final count of a quantum
    logic [6:0] half;       // final count of the first half

    assign half = {1'b0, quantum_prescale_value};
    assign last = {quantum_prescale_value, 1'b1};

    // counter restarts with the bit so the edge lands at a quantum start
    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            cnt <= 7'h00;
        end else if (cnt == last) begin
            cnt <= 7'h00;
        end else begin
            cnt <= cnt + 7'h01;
        end
    end

    // ticks are registered; they lag the count by one cycle, which is harmless
    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            tick <= '0;
        end else begin
            tick.tq_tick   <= (cnt == last);
            tick.half_tick <= (cnt == last) || (cnt == half);
        end
    end

    a_tq_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick.tq_tick && !restart) |=> !tick.tq_tick)
        else $error("quantum ticks closer than two cycles");
endmodule
`default_nettype wire

// ---- sim/can_bit_timing_dpll_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module can_bit_timing_dpll_tb_top;
    import canbt_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_bit = 1'b1, bus_idle = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic rx_bit, sample_pt, bit_start, txd, line, cur_bit;
    wire logic rxd = line & txd; // wired-and: dominant wins
    int mismatches = 0, n_tests = 0, n;
    // config words and bit lengths in clocks; every bit lasts at least 1 us
    localparam logic [31:0] CFGS [6] = '{32'h19103, 32'h08a06, 32'h02002,
                                         32'h00303, 32'h7bf00, 32'h1913f};
    localparam int LENS [6] = '{64, 112, 72, 64, 50, 1024};

    always #10 aclk = ~aclk;
    canbt_timing uut (.*);
    canbt_bus_model bus (.aclk(aclk), .line(line), .cur_bit(cur_bit));

    // ============================================
    // bus access and compare
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // ============================================
    // scenarios
    // first gap is partial after the restart, so it is skipped
    task automatic bit_len(input logic [31:0] cfg, input int exp);
        // own edges come back on rxd; a busy bus keeps them from hard-syncing
        bus_idle <= 1'b0;
        wr(CFG_OFFSET, cfg);
        for (int i = 0; i < 4; i++) begin
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while (bit_start !== 1'b1);
            if (i > 0) chk("bit length", n, exp);
            if (i > 0) chk("tx level", txd, tx_bit);
            // one dominant bit, then recessive so the next test starts high
            tx_bit <= (i < 2) ? ~tx_bit : 1'b1;
        end
    endtask
    task automatic rx_run(input logic [31:0] cfg, input int per);
        wr(CFG_OFFSET, cfg);
        bus_idle <= 1'b1;
        repeat (60) @(posedge aclk);
        fork
            bus.send(16'h6395, per);
            begin
                repeat (3) @(posedge aclk);
                for (int i = 0; i < 16; i++) begin
                    do @(posedge aclk); while (sample_pt !== 1'b1);
                    chk("rx bit", rx_bit, cur_bit);
                    bus_idle <= 1'b0;
                end
            end
        join
    endtask
    task automatic conclude();
        if (mismatches == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        mismatches++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(CFG_OFFSET);
        chk("cfg reset", rd, CFG_RESET);
        rd_reg(STATUS_OFFSET);
        chk("status idle", rd & 32'hffff_fff9, 32'h0000_0001);
        rd_reg(8'h08);
        chk("bad read", resp, RESP_SLVERR);
        wr(8'h08, 32'h1);
        chk("bad write", resp, RESP_SLVERR);
        wr(STATUS_OFFSET, 32'h1f);
        chk("status write", resp, RESP_OKAY);
        wr(CFG_OFFSET, 32'h0007ffff);
        rd_reg(CFG_OFFSET);
        chk("cfg readback", rd, 32'h0007ffff);
        for (int i = 0; i < 6; i++) bit_len(CFGS[i], LENS[i]);
        for (int p = 63; p < 66; p++) begin
            rx_run(32'h191c3, p);
            rx_run(32'h1d1c3, p);
        end
        // slow far node with a one-quantum jump width forces phase one lengthening
        rx_run(32'h19103, 68);
        conclude();
    end
endmodule
`default_nettype wire

// ---- sim/canbt_bus_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// far node: drives the bus line, idles recessive
module canbt_bus_model (
    input  wire logic aclk,
    output logic      line,
    output logic      cur_bit
);
    initial line = 1'b1;
    initial cur_bit = 1'b1;
    // one frame msb first; caller keeps equal runs to five bits
    task automatic send(input logic [15:0] pat, input int per);
        for (int i = 15; i >= 0; i--) begin
            line <= pat[i];
            cur_bit <= pat[i];
            repeat (per) @(posedge aclk);
        end
        line <= 1'b1;
    endtask
endmodule
`default_nettype wire
